// ### design/tbo_reg_map.svh
/*
 * Register offsets, field positions, reset values and frame constants
 * for the 10Base-T operations and extended control two registers.
 * Assumes inclusion by bare name from the design file, the checker, the station model and the bench.
 */
`ifndef TBO_REG_MAP_SVH
`define TBO_REG_MAP_SVH

// ****************************************
// Register addresses (clause 22, 5 bits)
// ****************************************
`define TBO_ADDR_TENBASE_OPS   5'h12
`define TBO_ADDR_EXT_CTRL_TWO  5'h13

// ****************************************
// Tenbase operations field positions
// ****************************************
`define TBO_OPS_REMOTE_JABBER  15
`define TBO_OPS_POL_REVERSED   14
`define TBO_OPS_JABBER_INH     5
`define TBO_OPS_AUTO_POL_INH   3
`define TBO_OPS_SQE_INH        2
`define TBO_OPS_LINK_LOSS_INH  1
`define TBO_OPS_SQUELCH_INH    0
`define TBO_OPS_RESET          16'h0010
`define TBO_OPS_WR_MASK        16'h3FFF

// ****************************************
// Extended control two field positions
// ****************************************
`define TBO_EXT_NODE_REP       15
`define TBO_EXT_HW_SW          14
`define TBO_EXT_REMOTE_FAULT   13
`define TBO_EXT_XOVER_EN       9
`define TBO_EXT_XOVER_SEL      8
`define TBO_EXT_TRISTATE       7
`define TBO_EXT_AUTO_PWRDN     0
`define TBO_EXT_RESET          16'h4201
`define TBO_EXT_WR_MASK        16'h1BFF

// ****************************************
// Management frame constants
// ****************************************
`define TBO_PHY_ADDR_DEF       5'h01
`define TBO_OP_READ            2'h2
`define TBO_OP_WRITE           2'h1
`define TBO_SQE_TIME_NS        1000
`define TBO_CLK_NS             10
`define TBO_SQE_CYCLES         (`TBO_SQE_TIME_NS / `TBO_CLK_NS)

`endif

// ### design/tbo_pkg.sv
/*
 * Types for the management register pair.
 * Assumes nothing beyond the constants header.
 */
package tbo_pkg;

    // ****************************************
    // Serial management frame states
    // ****************************************
    typedef enum logic [2:0] {
        TBO_IDLE,
        TBO_HEAD,
        TBO_TURN,
        TBO_READ,
        TBO_WRITE
    } tbo_frame_e;

endpackage : tbo_pkg

// ### design/tbo_regs.sv
/*
 * Serial management slave holding the 10Base-T operations register and
 * extended control register two, with the control outputs they steer.
 * Assumes mdc and mdio pins are asynchronous and are sampled here; mdc is
 * slow compared with clock_i; the phy address strap is stable after reset.
 */
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Polarity bit shows swapped receive pair
// [R2] Reversal never stops reception or functions
// [R3] Jabber inhibit disables transmit jabber check
// [R4] Auto polarity inhibit blocks pair correction
// [R5] Polarity correction works with crossover disabled
// [R6] SQE inhibit bit gates SQE generation
// [R7] SQE pulses collision after transmit ends
// [R8] SQE suppressed in full duplex, repeater
// [R9] SQE inhibit stored value never auto-changed
// [R10] Link loss inhibit forces link passed
// [R11] Squelch inhibit picks link establish condition
// [R12] Controller writes reserved bits with defaults
// [R13] Node repeater bit reads zero, node only
// [R14] Node mode: SQE on, carrier both ways
// [R15] Hardware software bit reads one always
// [R16] Remote fault bit mirrors partner fault
// [R17] Crossover enable and select register bits
// [R18] Crossover pairs from bits and pin
// [R19] Tristate bit floats transmit pair outputs
// [R20] Auto power down enable bit, default one
// [R21] Power down only in 10Base-T mode
// [R22] Access through clause 22 frames
`include "tbo_reg_map.svh"

module tbo_regs
    import tbo_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Serial management pins
    input  wire logic        mdc_i,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_o,
    input  wire logic [4:0]  phy_addr_i,
    // Status from line logic
    input  wire logic        pol_reversed_i,
    input  wire logic        remote_jabber_i,
    input  wire logic        remote_fault_i,
    input  wire logic        auto_crossover_enable_i,
    input  wire logic        auto_cross_choice_i,
    input  wire logic        full_duplex_i,
    input  wire logic        speed_10_i,
    input  wire logic        tx_en_i,
    input  wire logic        rx_active_i,
    // Controls to line logic
    output logic             jabber_check_en_o,
    output logic             auto_pol_en_o,
    output logic             link_force_pass_o,
    output logic             squelch_inhibit_o,
    output logic             pair_cross_o,
    output logic             pair_output_tristate_o,
    output logic             tx100_power_down_o,
    output logic             sqe_col_o,
    output logic             carrier_sense_o
);

    // ****************************************
    // Synchronisers and frame state
    // ****************************************
    logic [1:0]  mdc_sync_ff;                 // Mdc two-stage sync
    logic [1:0]  mdio_sync_ff;                // Mdio two-stage sync
    logic [1:0]  tx_sync_ff;                  // Transmit enable sync
    logic [1:0]  xpin_sync_ff;                // Crossover enable pin sync
    logic [4:0]  sts_sync_ff [0:1];           // Status bits sync
    logic        mdc_last_ff;                 // Previous synced mdc
    logic [4:0]  addr_ff;                     // Strap caught after reset
    logic        strap_done_ff;               // Strap capture done
    tbo_frame_e  state_ff, nxt_state;         // Frame state
    logic [5:0]  cnt_ff, nxt_cnt;             // Bit counter
    logic [13:0] head_ff, nxt_head;           // Start, op, addresses
    logic [15:0] shift_ff, nxt_shift;         // Data shifter
    logic        mdio_q_ff, nxt_mdio_q;       // Mdio out
    logic        mdio_oe_ff, nxt_mdio_oe;     // Mdio enable
    logic [15:0] ops_ff, nxt_ops;             // Tenbase operations
    logic [15:0] ext_ff, nxt_ext;             // Extended control two
    logic        rj_ff, nxt_rj;               // Remote jabber latch
    logic        pr_ff, nxt_pr;               // Polarity latch
    logic        tx_last_ff;                  // Previous transmit enable
    logic [7:0]  sqe_cnt_ff, nxt_sqe_cnt;     // SQE pulse timer
    logic [15:0] ctl_ff, nxt_ctl;             // Registered outputs
    logic        rise, fall, mine;

    // Readback value of one register address
    function automatic logic [15:0] tbo_read(input logic [4:0] a, input logic [15:0] ops,
                                             input logic [15:0] ext, input logic rj, input logic pr,
                                             input logic rf);
        logic [15:0] v;
        v = 16'h0000;
        if (a == `TBO_ADDR_TENBASE_OPS) begin
            v = ops;
            v[`TBO_OPS_REMOTE_JABBER] = rj;
            v[`TBO_OPS_POL_REVERSED] = pr;  // R1
        end else if (a == `TBO_ADDR_EXT_CTRL_TWO) begin
            v = ext;
            v[`TBO_EXT_NODE_REP] = 1'b0;  // R13
            v[`TBO_EXT_HW_SW] = 1'b1;  // R15
            v[`TBO_EXT_REMOTE_FAULT] = rf;  // R16
        end
        return v;
    endfunction : tbo_read

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Two flops on mdc, mdio, transmit enable, crossover pin and status inputs; speed and auto choice enter unsynced
    always_ff @(posedge clock_i) begin
        mdc_sync_ff  <= {mdc_sync_ff[0], mdc_i};
        mdio_sync_ff <= {mdio_sync_ff[0], mdio_i};
        tx_sync_ff   <= {tx_sync_ff[0], tx_en_i};
        xpin_sync_ff <= {xpin_sync_ff[0], auto_crossover_enable_i};
        sts_sync_ff[0] <= {pol_reversed_i, remote_jabber_i, remote_fault_i, full_duplex_i, rx_active_i};
        sts_sync_ff[1] <= sts_sync_ff[0];
    end

    assign rise = mdc_sync_ff[1] & ~mdc_last_ff;
    assign fall = ~mdc_sync_ff[1] & mdc_last_ff;
    assign mine = (head_ff[9:5] == addr_ff);

    // ****************************************
    // Frame and register next state
    // ****************************************
    // Clause 22 frame decode, register writes, latches
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_head = head_ff;
        nxt_shift = shift_ff;
        nxt_mdio_q = mdio_q_ff;
        nxt_mdio_oe = mdio_oe_ff;
        nxt_ops = ops_ff;
        nxt_ext = ext_ff;
        nxt_rj = rj_ff;
        nxt_pr = pr_ff;
        case (state_ff)
            TBO_IDLE: begin
                // Preamble ones, then a zero opens start field
                if (rise && !mdio_sync_ff[1]) begin
                    nxt_head = 14'h0000;
                    nxt_cnt = 6'h01;
                    nxt_state = TBO_HEAD;
                end
            end
            TBO_HEAD: begin
                if (rise) begin
                    nxt_head = {head_ff[12:0], mdio_sync_ff[1]};
                    nxt_cnt = cnt_ff + 6'h01;
                    if (cnt_ff == 6'h0D) begin
                        nxt_cnt = 6'h00;
                        nxt_state = TBO_TURN;
                    end
                end
            end
            TBO_TURN: begin
                // Start must be 01; op picks direction
                if (head_ff[13:12] != 2'h1 || !mine) begin
                    nxt_state = TBO_IDLE;  // R22
                end else if (head_ff[11:10] == `TBO_OP_READ) begin
                    nxt_shift = tbo_read(head_ff[4:0], ops_ff, ext_ff, rj_ff, pr_ff, sts_sync_ff[1][2]);
                    if (rise) begin
                        nxt_mdio_oe = 1'b1;
                        nxt_mdio_q = 1'b0;
                        nxt_state = TBO_READ;
                    end
                end else if (head_ff[11:10] == `TBO_OP_WRITE) begin
                    if (rise) begin
                        nxt_cnt = cnt_ff + 6'h01;
                        if (cnt_ff == 6'h01) begin
                            nxt_cnt = 6'h00;
                            nxt_state = TBO_WRITE;
                        end
                    end
                end else begin
                    nxt_state = TBO_IDLE;
                end
            end
            TBO_READ: begin
                // Second turnaround bit low, then data msb first on falling mdc
                if (fall) begin
                    if (cnt_ff == 6'h11) begin
                        nxt_mdio_oe = 1'b0;
                        nxt_state = TBO_IDLE;
                        if (head_ff[4:0] == `TBO_ADDR_TENBASE_OPS) begin
                            nxt_rj = 1'b0;
                            nxt_pr = 1'b0;
                        end
                    end else begin
                        // First fall keeps the turnaround zero on the pin
                        if (cnt_ff != 6'h00) begin
                            nxt_mdio_q = shift_ff[15];
                            nxt_shift = {shift_ff[14:0], 1'b0};
                        end
                        nxt_cnt = cnt_ff + 6'h01;
                    end
                end
            end
            TBO_WRITE: begin
                if (rise) begin
                    nxt_shift = {shift_ff[14:0], mdio_sync_ff[1]};
                    nxt_cnt = cnt_ff + 6'h01;
                    if (cnt_ff == 6'h0F) begin
                        nxt_state = TBO_IDLE;
                        // Reserved bits stored as written, except extended control two bit 10, which keeps its value  R12
                        if (head_ff[4:0] == `TBO_ADDR_TENBASE_OPS) begin
                            nxt_ops = ({shift_ff[14:0], mdio_sync_ff[1]} & `TBO_OPS_WR_MASK);  // R9
                        end else if (head_ff[4:0] == `TBO_ADDR_EXT_CTRL_TWO) begin
                            nxt_ext = ({shift_ff[14:0], mdio_sync_ff[1]} & `TBO_EXT_WR_MASK)  // R17
                                    | (ext_ff & ~`TBO_EXT_WR_MASK);
                        end
                    end
                end
            end
            default: begin
                nxt_state = TBO_IDLE;
            end
        endcase
        // Latching high status; event beats the read clear  R1
        if (sts_sync_ff[1][4]) begin
            nxt_pr = 1'b1;
        end
        if (sts_sync_ff[1][3]) begin
            nxt_rj = 1'b1;
        end
    end

    // ****************************************
    // Line controls next state
    // ****************************************
    // SQE timer and derived control levels
    always_comb begin
        nxt_sqe_cnt = sqe_cnt_ff;
        // Node only, so only duplex suppresses SQE  R8
        if (tx_last_ff && !tx_sync_ff[1] && !ops_ff[`TBO_OPS_SQE_INH] && !sts_sync_ff[1][1]) begin
            nxt_sqe_cnt = 8'(`TBO_SQE_CYCLES);  // R7
        end else if (sqe_cnt_ff != 8'h00) begin
            nxt_sqe_cnt = sqe_cnt_ff - 8'h01;
        end
        nxt_ctl = 16'h0000;
        nxt_ctl[0] = ~ops_ff[`TBO_OPS_JABBER_INH];  // R3
        nxt_ctl[1] = ~ops_ff[`TBO_OPS_AUTO_POL_INH];  // R4
        nxt_ctl[2] = ops_ff[`TBO_OPS_LINK_LOSS_INH];  // R10
        nxt_ctl[3] = ops_ff[`TBO_OPS_SQUELCH_INH];  // R11
        // Manual pairs, pin low straight, else auto  R18
        if (!ext_ff[`TBO_EXT_XOVER_EN]) begin
            nxt_ctl[4] = ext_ff[`TBO_EXT_XOVER_SEL];
        end else if (!xpin_sync_ff[1]) begin
            nxt_ctl[4] = 1'b0;
        end else begin
            nxt_ctl[4] = auto_cross_choice_i;  // R5
        end
        nxt_ctl[5] = ext_ff[`TBO_EXT_TRISTATE];  // R19
        nxt_ctl[6] = ext_ff[`TBO_EXT_AUTO_PWRDN] & speed_10_i;  // R20 R21
        nxt_ctl[7] = (sqe_cnt_ff != 8'h00);  // R6
        nxt_ctl[8] = tx_sync_ff[1] | sts_sync_ff[1][0];  // R14
    end

    // ****************************************
    // State registers
    // ****************************************
    // Reset loads defaults; strap caught after release
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_ff <= TBO_IDLE;
            cnt_ff <= 6'h00;
            head_ff <= 14'h0000;
            shift_ff <= 16'h0000;
            mdio_q_ff <= 1'b0;
            mdio_oe_ff <= 1'b0;
            ops_ff <= `TBO_OPS_RESET;
            ext_ff <= `TBO_EXT_RESET;
            rj_ff <= 1'b0;
            pr_ff <= 1'b0;
            mdc_last_ff <= 1'b0;
            tx_last_ff <= 1'b0;
            sqe_cnt_ff <= 8'h00;
            ctl_ff <= 16'h0000;
            strap_done_ff <= 1'b0;
            addr_ff <= `TBO_PHY_ADDR_DEF;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            head_ff <= nxt_head;
            shift_ff <= nxt_shift;
            mdio_q_ff <= nxt_mdio_q;
            mdio_oe_ff <= nxt_mdio_oe;
            ops_ff <= nxt_ops;
            ext_ff <= nxt_ext;
            rj_ff <= nxt_rj;
            pr_ff <= nxt_pr;
            mdc_last_ff <= mdc_sync_ff[1];
            tx_last_ff <= tx_sync_ff[1];
            sqe_cnt_ff <= nxt_sqe_cnt;
            ctl_ff <= nxt_ctl;
            strap_done_ff <= 1'b1;
            if (!strap_done_ff) begin
                addr_ff <= phy_addr_i;
            end
        end
    end

    // ****************************************
    // Outputs, all from flops
    // ****************************************
    // Polarity status never gates any control  R2
    assign mdio_o = mdio_q_ff;
    assign mdio_oe_o = mdio_oe_ff;
    assign jabber_check_en_o = ctl_ff[0];
    assign auto_pol_en_o = ctl_ff[1];
    assign link_force_pass_o = ctl_ff[2];
    assign squelch_inhibit_o = ctl_ff[3];
    assign pair_cross_o = ctl_ff[4];
    assign pair_output_tristate_o = ctl_ff[5];
    assign tx100_power_down_o = ctl_ff[6];
    assign sqe_col_o = ctl_ff[7];
    assign carrier_sense_o = ctl_ff[8];

endmodule : tbo_regs

// ### verif/tbo_regs_props.sv
/* Checker on the block pins: carrier sense, collision test pulse,
   power-down and data pin drive.
   Assumes it is bound to tbo_regs and sees only its ports. */
`timescale 1ns/100ps
`include "tbo_reg_map.svh"
module tbo_regs_chk (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Block inputs
    input wire logic tx_en_i,
    input wire logic rx_active_i,
    input wire logic full_duplex_i,
    input wire logic speed_10_i,
    // Block outputs and the mdc input
    input wire logic mdio_o,
    input wire logic mdio_oe_o,
    input wire logic mdc_i,
    input wire logic sqe_col_o,
    input wire logic carrier_sense_o,
    input wire logic tx100_power_down_o
);
    // ****************
    // Helper counters
    // ****************
    logic [7:0] sqe_cnt_ff, nxt_sqe_cnt; // Pulse length so far
    logic [8:0] oe_cnt_ff, nxt_oe_cnt;   // Drive length so far
    // Count high cycles, cleared in reset
    always_comb begin
        nxt_sqe_cnt = (rst_n_i && sqe_col_o) ? sqe_cnt_ff + 8'h01 : 8'h00;
        nxt_oe_cnt = (rst_n_i && mdio_oe_o) ? oe_cnt_ff + 9'h001 : 9'h000;
    end
    // Register the counters
    always_ff @(posedge clock_i) begin
        sqe_cnt_ff <= nxt_sqe_cnt;
        oe_cnt_ff <= nxt_oe_cnt;
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_busy; rx_active_i [*6]; endsequence
    sequence s_quiet; (!tx_en_i && !rx_active_i) [*6]; endsequence
    a_crs_busy:
        assert property (s_busy |-> carrier_sense_o) else $error("carrier sense low");
    a_crs_quiet:
        assert property (s_quiet |-> !carrier_sense_o) else $error("carrier sense high");
    a_sqe_width:
        assert property ($fell(sqe_col_o) |-> sqe_cnt_ff == `TBO_SQE_CYCLES) else $error("pulse length");
    a_sqe_cause:
        assert property ($rose(sqe_col_o) |-> !tx_en_i && !full_duplex_i && !$past(full_duplex_i, 4))
        else $error("collision pulse out of place");
    a_pwrdn_mode:
        assert property (!$past(speed_10_i) |-> !tx100_power_down_o) else $error("power-down outside 10M");
    a_oe_steady:
        assert property (mdio_oe_o && $past(mdio_oe_o) && mdc_i && $past(mdc_i) |-> $stable(mdio_o))
        else $error("read bit moved");
    a_oe_bounded:
        assert property (oe_cnt_ff <= 9'h0B9) else $error("data drive too long");
    a_rst_quiet:
        assert property ($rose(rst_n_i) |-> !mdio_oe_o && !sqe_col_o && !tx100_power_down_o)
        else $error("outputs active in reset");
endmodule : tbo_regs_chk
bind tbo_regs tbo_regs_chk chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .tx_en_i(tx_en_i),
    .rx_active_i(rx_active_i), .full_duplex_i(full_duplex_i), .speed_10_i(speed_10_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .mdc_i(mdc_i), .sqe_col_o(sqe_col_o),
    .carrier_sense_o(carrier_sense_o), .tx100_power_down_o(tx100_power_down_o));

// ### verif/tbo_sta_model.sv
/* Station manager model: makes the management clock and frames.
   Assumes a pull-up on the data pin and a 10 ns bench clock. */
`timescale 1ns/100ps
`include "tbo_reg_map.svh"
module tbo_sta_model (
    // Bench clock
    input  wire logic clock_i,
    // Device drive of the data pin
    input  wire logic dev_mdio_i,
    input  wire logic dev_oe_i,
    // Pin levels seen by the device
    output logic      mdc_o,
    output logic      mdio_o
);
    logic drv_en = 1'b0;  // Model drives the pin
    logic drv_val = 1'b1; // Level it drives
    // Device, else model, else the pull-up
    assign mdio_o = dev_oe_i ? dev_mdio_i : (drv_en ? drv_val : 1'b1);
    initial mdc_o = 1'b0;
    // One bit of ten cycles, pin sampled at the rise
    task automatic bit_cyc(input logic b, input logic en, output logic s);
        @(negedge clock_i);
        mdc_o = 1'b0;
        drv_en = en;
        drv_val = b;
        repeat (5) @(negedge clock_i);
        s = mdio_o;
        mdc_o = 1'b1;
        repeat (4) @(negedge clock_i);
    endtask : bit_cyc
    // Whole frame; clock low and pin released after it
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic        s;
        logic [15:0] hd;
        logic [17:0] tl;
        hd = {4'hD, op, pa, ra}; // Two preamble ones, then start 01
        tl = {2'b10, wd};
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(hd[i], 1'b1, s);
        end
        for (int i = 17; i >= 0; i--) begin
            bit_cyc(tl[i], op == `TBO_OP_WRITE, s);
            rd = {rd[14:0], s};
        end
        @(negedge clock_i);
        mdc_o = 1'b0;
        drv_en = 1'b0;
        repeat (5) @(negedge clock_i);
    endtask : frame
endmodule : tbo_sta_model

// ### verif/tenbase_ops_ext_ctrl_regs_bench.sv
/* Bench for the register pair: frames from the station model, line
   stimulus, controls compared with expected values.
   Assumes model and checker files compile first. */
`timescale 1ns/100ps
`include "tbo_reg_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tenbase_ops_ext_ctrl_regs_bench;
    localparam logic [4:0] PA = 5'h05; // Strapped address
    localparam logic [4:0] OPS = `TBO_ADDR_TENBASE_OPS;
    localparam logic [4:0] EXT = `TBO_ADDR_EXT_CTRL_TWO;
    logic       clock_i, rst_n_i, mdc, mdio, mdo, mdo_en; // Clock, pins
    logic       pol, rjab, rflt, xpin, xsel, fdx, spd, txe, rxa; // Line
    wire  [6:0] ctl_w;          // Control outputs
    logic       sqe, crs;       // Collision, carrier
    int         cmp_count = 0;  // Comparisons
    int         n_mismatch = 0; // Mismatches
    int         cyc = 0;        // Run length
    tbo_regs dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(mdo),
        .mdio_oe_o(mdo_en), .phy_addr_i(PA), .pol_reversed_i(pol), .remote_jabber_i(rjab),
        .remote_fault_i(rflt), .auto_crossover_enable_i(xpin), .auto_cross_choice_i(xsel),
        .full_duplex_i(fdx), .speed_10_i(spd), .tx_en_i(txe), .rx_active_i(rxa),
        .jabber_check_en_o(ctl_w[6]), .auto_pol_en_o(ctl_w[5]), .link_force_pass_o(ctl_w[4]),
        .squelch_inhibit_o(ctl_w[3]), .pair_cross_o(ctl_w[2]), .pair_output_tristate_o(ctl_w[1]),
        .tx100_power_down_o(ctl_w[0]), .sqe_col_o(sqe), .carrier_sense_o(crs));
    tbo_sta_model sta_u (.clock_i(clock_i), .dev_mdio_i(mdo), .dev_oe_i(mdo_en), .mdc_o(mdc), .mdio_o(mdio));
    // Bench clock, 10 ns
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Cut a hung run short
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Verdict and stop
    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // Read and compare
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] got;
        sta_u.frame(`TBO_OP_READ, pa, ra, 16'h0000, got);
        `CHK("read data", exp, got)
    endtask : rd
    // Write and settle
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] got;
        sta_u.frame(`TBO_OP_WRITE, PA, ra, wd, got);
        repeat (6) @(negedge clock_i);
    endtask : wr
    // Settle, compare controls
    task automatic ctl(input logic [6:0] exp);
        repeat (4) @(negedge clock_i);
        `CHK("controls", exp, ctl_w)
    endtask : ctl
    // One packet, watch for the collision pulse
    task automatic pkt(input logic exp);
        logic seen;
        seen = 1'b0;
        txe = 1'b1;
        repeat (20) @(negedge clock_i);
        `CHK("carrier", 1'b1, crs)
        txe = 1'b0;
        repeat (150) begin
            @(negedge clock_i);
            seen = seen | sqe;
        end
        `CHK("collision pulse", exp, seen)
    endtask : pkt
    // Main sequence
    initial begin
        {rst_n_i, pol, rjab, rflt, xsel, fdx, txe, rxa} = 8'h00;
        {xpin, spd} = 2'b11;
        repeat (20) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (6) @(negedge clock_i);
        rd(PA, EXT, 16'h4201);
        rd(PA, OPS, 16'h0010);
        ctl(7'b1100001);
        xsel = 1'b1;
        ctl(7'b1100101);
        xpin = 1'b0;
        ctl(7'b1100001);
        spd = 1'b0;
        ctl(7'b1100000);
        {xpin, spd} = 2'b11;
        rd(PA, 5'h1F, 16'h0000);
        rd(~PA, EXT, 16'hFFFF);
        wr(5'h1F, 16'hFFFF);
        wr(OPS, 16'h003F);
        rd(PA, OPS, 16'h003F);
        ctl(7'b0011101);
        pkt(1'b0);
        wr(OPS, 16'h0010);
        pkt(1'b1);
        fdx = 1'b1;
        pkt(1'b0);
        rd(PA, OPS, 16'h0010);
        fdx = 1'b0;
        {pol, rjab} = 2'b11;
        repeat (3) @(negedge clock_i);
        {pol, rjab} = 2'b00;
        ctl(7'b1100101);
        rd(PA, OPS, 16'hC010);
        rd(PA, OPS, 16'h0010);
        rflt = 1'b1;
        wr(EXT, 16'hA180);
        rd(PA, EXT, 16'h6180);
        ctl(7'b1100110);
        wr(EXT, 16'h0000);
        ctl(7'b1100000);
        rflt = 1'b0;
        wr(EXT, 16'h0201);
        rd(PA, EXT, 16'h4201);
        rxa = 1'b1;
        repeat (8) @(negedge clock_i);
        `CHK("carrier", 1'b1, crs)
        rxa = 1'b0;
        repeat (8) @(negedge clock_i);
        `CHK("carrier", 1'b0, crs)
        wrap_up();
    end
endmodule : tenbase_ops_ext_ctrl_regs_bench
